//--- hdl/ovp_pkg.sv
/*
 * Shared constants and enumerations for the two-stage overvoltage protection.
 * Assumes fundamental phasors are formed from a fixed number of samples per
 * period delivered by the measurement front end on the processing clock.
 */
package ovp_pkg;
   localparam int SAMPLE_W = 16;
   localparam int PHASOR_W = 20;
   localparam int MAG_W = 2 * PHASOR_W + 1;
   localparam int DELAY_W = 16;
   localparam int RATIO_W = 8;
   localparam int RATIO_FRAC = 8;
   localparam int Q_FRAC = 14;
   localparam logic signed [PHASOR_W-1:0] SQRT3_HALF_Q = 20'sh0376D;
   localparam logic signed [PHASOR_W-1:0] THIRD_Q = 20'sh01555;
   localparam int SAMPLES_PER_PERIOD = 4;
   localparam int RESTRAINT_PERIODS = 3;
   localparam int RESTRAINT_SAMPLES = SAMPLES_PER_PERIOD * RESTRAINT_PERIODS;
   localparam int CLK_PERIOD_NS = 40;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int N_FN = 5;
   localparam int N_STAGE = 2 * N_FN;
   localparam int N_QTY = 9;
   localparam int N_CHAN = 7;
   localparam int N_SYNC = 6;
   localparam int FN_PE = 0;
   localparam int FN_LL = 1;
   localparam int FN_POS = 2;
   localparam int FN_NEG = 3;
   localparam int FN_ZERO = 4;
   localparam int QTY_POS = 6;
   localparam int QTY_NEG = 7;
   localparam int QTY_ZERO = 8;

   typedef enum logic [1:0] {FN_OFF, FN_ON, FN_ALARM} fn_mode_e;
   typedef enum logic [1:0] {SCOPE_DISABLED, SCOPE_ENABLED, SCOPE_COMPOUND} scope_e;
   typedef enum logic [1:0] {U4_UNUSED, U4_DELTA, U4_SINGLE} u4_use_e;
endpackage

//--- hdl/phasor_filter.sv
/*
 * Sliding fundamental filter for one measuring channel.
 * Assumes a new sample at each sample_valid pulse, a fixed number per period.
 */
`timescale 1ns/100ps
`default_nettype none
module phasor_filter #(
   parameter int W = ovp_pkg::SAMPLE_W,
   parameter int PW = ovp_pkg::PHASOR_W
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic sample_valid,
   input wire logic signed [W-1:0] sample,
   output logic signed [PW-1:0] re,
   output logic signed [PW-1:0] im,
   output logic valid
);
   // A four-point transform rejects DC and even harmonics cheaply; the phasor
   // rotates a quarter turn per sample, identically on every channel.
   logic signed [W-1:0] hist [3];
   wire logic signed [PW-1:0] next_re = PW'(sample) - PW'(hist[1]);
   wire logic signed [PW-1:0] next_im = PW'(hist[0]) - PW'(hist[2]);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hist <= '{default: '0};
         re <= '0;
         im <= '0;
         valid <= 1'b0;
      end
      else
      begin
         valid <= sample_valid;
         if (sample_valid)
         begin
            hist[0] <= sample;
            hist[1] <= hist[0];
            hist[2] <= hist[1];
            re <= next_re;
            im <= next_im;
         end
      end
   end
endmodule
`default_nettype wire

//--- hdl/level_detect.sv
/*
 * Overvoltage threshold detector with settable dropout-to-pickup ratio.
 * Assumes squared magnitudes in the same scale as the squared threshold.
 */
`timescale 1ns/100ps
`default_nettype none
module level_detect #(
   parameter int MW = ovp_pkg::MAG_W,
   parameter int TW = ovp_pkg::SAMPLE_W,
   parameter int RW = ovp_pkg::RATIO_W
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic update,
   input wire logic block,
   input wire logic [MW-1:0] mag_sq,
   input wire logic [TW-1:0] thr,
   input wire logic [RW-1:0] ratio,
   output logic pick
);
   // Squared compare avoids a square root at the cost of wide multipliers.
   wire logic [TW+RW-1:0] rel_prod = (TW+RW)'(thr) * (TW+RW)'(ratio);
   wire logic [TW-1:0] rel = rel_prod[TW+ovp_pkg::RATIO_FRAC-1:ovp_pkg::RATIO_FRAC];
   wire logic [MW-1:0] thr_sq = MW'(thr) * MW'(thr);
   wire logic [MW-1:0] rel_sq = MW'(rel) * MW'(rel);
   wire logic next_pick = pick ? !(mag_sq < rel_sq) : (mag_sq > thr_sq);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         pick <= 1'b0;
      else if (block)
         pick <= 1'b0;
      else if (update)
         pick <= next_pick;
   end
endmodule
`default_nettype wire

//--- hdl/overvoltage_protection_stages.sv
/*
 * Two-stage overvoltage protection: phase-earth, phase-phase, positive,
 * negative and zero sequence (or single-phase) quantities with delay timers.
 * Assumes voltage and current samples with a common strobe on clk, settings
 * held stable, and dead-time and voltage-failure flags from logic on clk.
 */
// Contract
// - per-phase fundamental compared with two thresholds
// - general pickup per phase-earth stage
// - configurable dropout ratio releases picked stage
// - stage timer expiry signalled, trips normally
// - each function off, on or alarm-only
// - phase-earth block input inhibits stages
// - phase-phase stages with own block
// - positive sequence feeds two delayed stages
// - positive sequence block input inhibits
// - compounding only with compounding scope, reported
// - remote voltage via PI line model
// - negative sequence feeds two delayed stages
// - negative sequence blocked by block, failure, breaker
// - negative sequence blocked in own dead time
// - zero sequence stages with optional restraint
// - zero sequence blocked by block, failure, breaker
// - zero sequence blocked in own dead time
// - zero sequence as sum without fourth input
// - open-delta input scaled by configured ratio
// - single-phase fourth input, only block input
`timescale 1ns/100ps
`default_nettype none
module overvoltage_protection_stages #(
   parameter int W = ovp_pkg::SAMPLE_W,
   parameter int PW = ovp_pkg::PHASOR_W,
   parameter int MW = ovp_pkg::MAG_W,
   parameter int DW = ovp_pkg::DELAY_W,
   parameter int RW = ovp_pkg::RATIO_W,
   parameter int TICK_CYCLES = ovp_pkg::MS_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic sample_valid,
   input wire logic signed [W-1:0] v_l1,
   input wire logic signed [W-1:0] v_l2,
   input wire logic signed [W-1:0] v_l3,
   input wire logic signed [W-1:0] fourth_voltage_input,
   input wire logic signed [W-1:0] i_l1,
   input wire logic signed [W-1:0] i_l2,
   input wire logic signed [W-1:0] i_l3,
   input wire ovp_pkg::scope_e voltage_scope,
   input wire ovp_pkg::u4_use_e u4_use,
   input wire logic [W-1:0] phase_to_delta_ratio,
   input wire logic signed [W-1:0] line_half_susceptance,
   input wire logic signed [W-1:0] line_resistance,
   input wire logic signed [W-1:0] line_reactance,
   input wire ovp_pkg::fn_mode_e phase_earth_mode,
   input wire ovp_pkg::fn_mode_e line_line_mode,
   input wire ovp_pkg::fn_mode_e pos_seq_mode,
   input wire ovp_pkg::fn_mode_e neg_seq_mode,
   input wire ovp_pkg::fn_mode_e zero_seq_mode,
   input wire logic [W-1:0] phase_earth_stage1_threshold,
   input wire logic [W-1:0] phase_earth_stage2_threshold,
   input wire logic [W-1:0] line_line_stage1_threshold,
   input wire logic [W-1:0] line_line_stage2_threshold,
   input wire logic [W-1:0] pos_seq_stage1_threshold,
   input wire logic [W-1:0] pos_seq_stage2_threshold,
   input wire logic [W-1:0] neg_seq_stage1_threshold,
   input wire logic [W-1:0] neg_seq_stage2_threshold,
   input wire logic [W-1:0] zero_seq_stage1_threshold,
   input wire logic [W-1:0] zero_seq_stage2_threshold,
   input wire logic [RW-1:0] phase_earth_dropout_ratio,
   input wire logic [RW-1:0] line_line_dropout_ratio,
   input wire logic [RW-1:0] pos_seq_dropout_ratio,
   input wire logic [RW-1:0] neg_seq_dropout_ratio,
   input wire logic [RW-1:0] zero_seq_dropout_ratio,
   input wire logic [ovp_pkg::N_STAGE-1:0][DW-1:0] stage_delay_ms,
   input wire logic zero_seq_restraint_on,
   input wire logic phase_earth_block_in,
   input wire logic line_line_block_in,
   input wire logic pos_seq_block_in,
   input wire logic neg_seq_block_in,
   input wire logic zero_seq_block_in,
   input wire logic vt_breaker_tripped_in,
   input wire logic asym_vfail,
   input wire logic own_sp_dead_time,
   output logic [1:0][2:0] phase_earth_phase_pickup,
   output logic [1:0][2:0] line_line_pair_pickup,
   output logic [ovp_pkg::N_STAGE-1:0] general_pickup,
   output logic [ovp_pkg::N_STAGE-1:0] stage_expired,
   output logic overvoltage_trip,
   output logic signed [PW-1:0] remote_end_re,
   output logic signed [PW-1:0] remote_end_im,
   output logic remote_end_valid
);
   localparam int NQ = ovp_pkg::N_QTY;
   localparam int NS = ovp_pkg::N_STAGE;
   localparam int TCW = $clog2(TICK_CYCLES + 1);
   localparam int RCW = $clog2(ovp_pkg::RESTRAINT_SAMPLES + 1);
   localparam logic [RCW-1:0] RESTRAINT_N = RCW'(ovp_pkg::RESTRAINT_SAMPLES);

   function automatic logic signed [PW-1:0] kmul(input logic signed [PW-1:0] x,
                                                 input logic signed [PW-1:0] k);
      logic signed [2*PW-1:0] p;
      p = x * k;
      return PW'(p >>> ovp_pkg::Q_FRAC);
   endfunction

   // One component of a symmetrical sequence; neg selects the a-squared order.
   function automatic logic signed [PW-1:0] seq(input logic signed [PW-1:0] a,
      input logic signed [PW-1:0] b, input logic signed [PW-1:0] c,
      input logic signed [PW-1:0] p, input logic signed [PW-1:0] q, input logic neg);
      logic signed [PW-1:0] rot;
      rot = kmul(neg ? q - p : p - q, ovp_pkg::SQRT3_HALF_Q);
      return kmul(a - (b >>> 1) - (c >>> 1) + rot, ovp_pkg::THIRD_Q);
   endfunction

   function automatic logic [MW-1:0] mag_sq(input logic signed [PW-1:0] re,
                                             input logic signed [PW-1:0] im);
      logic signed [2*PW-1:0] a;
      logic signed [2*PW-1:0] b;
      a = re * re;
      b = im * im;
      return MW'(unsigned'(a)) + MW'(unsigned'(b));
   endfunction

   function automatic int fn_of(input int q);
      return (q < 3) ? ovp_pkg::FN_PE : (q < 6) ? ovp_pkg::FN_LL : q - 4;
   endfunction

   // Channel filters: 0..2 phase voltages, 3 fourth input, 4..6 currents.
   wire logic signed [W-1:0] chan [ovp_pkg::N_CHAN];
   logic signed [PW-1:0] ph_re [ovp_pkg::N_CHAN];
   logic signed [PW-1:0] ph_im [ovp_pkg::N_CHAN];
   logic [ovp_pkg::N_CHAN-1:0] ph_valid;
   assign chan = '{v_l1, v_l2, v_l3, fourth_voltage_input, i_l1, i_l2, i_l3};

   for (genvar c = 0; c < ovp_pkg::N_CHAN; c++)
   begin : g_chan
      phasor_filter #(.W(W), .PW(PW)) u_filt (
         .clk(clk),
         .rst_b(rst_b),
         .sample_valid(sample_valid),
         .sample(chan[c]),
         .re(ph_re[c]),
         .im(ph_im[c]),
         .valid(ph_valid[c])
      );
   end

   // Block inputs from pins pass two flip-flops before use.
   logic [ovp_pkg::N_SYNC-1:0] sync1;
   logic [ovp_pkg::N_SYNC-1:0] sync2;
   wire logic [ovp_pkg::N_SYNC-1:0] raw_in = {vt_breaker_tripped_in, zero_seq_block_in,
      neg_seq_block_in, pos_seq_block_in, line_line_block_in, phase_earth_block_in};
   wire logic vt_tripped = sync2[5];

   // Sequence quantities.
   wire logic signed [PW-1:0] u1_re = seq(ph_re[0], ph_re[1], ph_re[2], ph_im[2], ph_im[1], 1'b0);
   wire logic signed [PW-1:0] u1_im = seq(ph_im[0], ph_im[1], ph_im[2], ph_re[1], ph_re[2], 1'b0);
   wire logic signed [PW-1:0] u2_re = seq(ph_re[0], ph_re[1], ph_re[2], ph_im[2], ph_im[1], 1'b1);
   wire logic signed [PW-1:0] u2_im = seq(ph_im[0], ph_im[1], ph_im[2], ph_re[1], ph_re[2], 1'b1);
   wire logic signed [PW-1:0] i1_re = seq(ph_re[4], ph_re[5], ph_re[6], ph_im[6], ph_im[5], 1'b0);
   wire logic signed [PW-1:0] i1_im = seq(ph_im[4], ph_im[5], ph_im[6], ph_re[5], ph_re[6], 1'b0);

   // Remote end: U - (I - jB/2 U)(R + jX).
   wire logic signed [PW-1:0] b_half = PW'(line_half_susceptance);
   wire logic signed [PW-1:0] r_line = PW'(line_resistance);
   wire logic signed [PW-1:0] x_line = PW'(line_reactance);
   wire logic signed [PW-1:0] t_re = i1_re + kmul(b_half, u1_im);
   wire logic signed [PW-1:0] t_im = i1_im - kmul(b_half, u1_re);
   wire logic signed [PW-1:0] end_re = u1_re - (kmul(t_re, r_line) - kmul(t_im, x_line));
   wire logic signed [PW-1:0] end_im = u1_im - (kmul(t_re, x_line) + kmul(t_im, r_line));
   wire logic compounding = (voltage_scope == ovp_pkg::SCOPE_COMPOUND);

   // Zero sequence source.
   wire logic signed [PW-1:0] dr = PW'(signed'({1'b0, phase_to_delta_ratio}));
   wire logic signed [2*PW-1:0] d_re = ph_re[3] * dr;
   wire logic signed [2*PW-1:0] d_im = ph_im[3] * dr;
   wire logic u4_single = (u4_use == ovp_pkg::U4_SINGLE);
   wire logic u4_delta = (u4_use == ovp_pkg::U4_DELTA);
   wire logic signed [PW-1:0] z_re = u4_single ? ph_re[3]
      : u4_delta ? PW'(d_re >>> ovp_pkg::RATIO_FRAC)
      : ph_re[0] + ph_re[1] + ph_re[2];
   wire logic signed [PW-1:0] z_im = u4_single ? ph_im[3]
      : u4_delta ? PW'(d_im >>> ovp_pkg::RATIO_FRAC)
      : ph_im[0] + ph_im[1] + ph_im[2];

   wire logic signed [PW-1:0] q_re [NQ];
   wire logic signed [PW-1:0] q_im [NQ];
   assign q_re = '{ph_re[0], ph_re[1], ph_re[2], ph_re[0] - ph_re[1], ph_re[1] - ph_re[2],
      ph_re[2] - ph_re[0], compounding ? end_re : u1_re, u2_re, z_re};
   assign q_im = '{ph_im[0], ph_im[1], ph_im[2], ph_im[0] - ph_im[1], ph_im[1] - ph_im[2],
      ph_im[2] - ph_im[0], compounding ? end_im : u1_im, u2_im, z_im};

   // Settings per function and per stage.
   wire ovp_pkg::fn_mode_e fn_mode [ovp_pkg::N_FN];
   wire logic [W-1:0] thr_of [NS];
   wire logic [RW-1:0] ratio_of [ovp_pkg::N_FN];
   assign fn_mode = '{phase_earth_mode, line_line_mode, pos_seq_mode, neg_seq_mode,
      zero_seq_mode};
   assign thr_of = '{phase_earth_stage1_threshold, phase_earth_stage2_threshold,
      line_line_stage1_threshold, line_line_stage2_threshold, pos_seq_stage1_threshold,
      pos_seq_stage2_threshold, neg_seq_stage1_threshold, neg_seq_stage2_threshold,
      zero_seq_stage1_threshold, zero_seq_stage2_threshold};
   assign ratio_of = '{phase_earth_dropout_ratio, line_line_dropout_ratio,
      pos_seq_dropout_ratio, neg_seq_dropout_ratio, zero_seq_dropout_ratio};

   wire logic scope_off = (voltage_scope == ovp_pkg::SCOPE_DISABLED);
   wire logic internal_block = asym_vfail | vt_tripped;
   wire logic neg_block = sync2[3] | internal_block | own_sp_dead_time;
   wire logic zero_block = sync2[4] | (!u4_single & (internal_block | own_sp_dead_time));
   wire logic [ovp_pkg::N_FN-1:0] fn_block;
   wire logic [NS-1:0] trip_allow;
   for (genvar f = 0; f < ovp_pkg::N_FN; f++)
   begin : g_fn
      wire logic off = scope_off | (fn_mode[f] == ovp_pkg::FN_OFF);
      if (f == ovp_pkg::FN_NEG)
         assign fn_block[f] = off | neg_block;
      else if (f == ovp_pkg::FN_ZERO)
         assign fn_block[f] = off | zero_block;
      else
         assign fn_block[f] = off | sync2[f];
      assign trip_allow[2*f+1:2*f] = {2{fn_mode[f] == ovp_pkg::FN_ON}};
   end

   // Magnitudes are registered once per new phasor set.
   logic [MW-1:0] qm [NQ];
   logic q_valid;
   logic [NQ-1:0] det [2];
   logic [1:0][RCW-1:0] conf_cnt;
   wire logic [1:0] zero_ok;
   wire logic [NS-1:0] stage_pick;

   for (genvar q = 0; q < NQ; q++)
   begin : g_qty
      localparam int F = fn_of(q);
      for (genvar s = 0; s < 2; s++)
      begin : g_stg
         level_detect #(.MW(MW), .TW(W), .RW(RW)) u_det (
            .clk(clk),
            .rst_b(rst_b),
            .update(q_valid),
            .block(fn_block[F]),
            .mag_sq(qm[q]),
            .thr(thr_of[2*F+s]),
            .ratio(ratio_of[F]),
            .pick(det[s][q])
         );
      end
   end

   // Restraint: a zero sequence pickup must persist over several measurements.
   for (genvar s = 0; s < 2; s++)
   begin : g_rst
      assign zero_ok[s] = det[s][ovp_pkg::QTY_ZERO]
         & (!zero_seq_restraint_on | (conf_cnt[s] == RESTRAINT_N));
      assign stage_pick[2*ovp_pkg::FN_PE+s] = |det[s][2:0];
      assign stage_pick[2*ovp_pkg::FN_LL+s] = |det[s][5:3];
      assign stage_pick[2*ovp_pkg::FN_POS+s] = det[s][ovp_pkg::QTY_POS];
      assign stage_pick[2*ovp_pkg::FN_NEG+s] = det[s][ovp_pkg::QTY_NEG];
      assign stage_pick[2*ovp_pkg::FN_ZERO+s] = zero_ok[s];
   end

   // Millisecond tick for all stage timers.
   logic [TCW-1:0] tick_cnt;
   wire logic tick = (tick_cnt == TCW'(TICK_CYCLES - 1));
   logic [NS-1:0][DW-1:0] stage_timer;

   for (genvar i = 0; i < NS; i++)
   begin : g_tmr
      wire logic done = (stage_timer[i] >= stage_delay_ms[i]);
      always_ff @(posedge clk or negedge rst_b)
      begin
         if (!rst_b)
         begin
            stage_timer[i] <= '0;
            stage_expired[i] <= 1'b0;
         end
         else if (!stage_pick[i])
         begin
            stage_timer[i] <= '0;
            stage_expired[i] <= 1'b0;
         end
         else
         begin
            if (tick && !done)
               stage_timer[i] <= stage_timer[i] + DW'(1);
            stage_expired[i] <= done;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sync1 <= '0;
         sync2 <= '0;
         tick_cnt <= '0;
         q_valid <= 1'b0;
         qm <= '{default: '0};
         conf_cnt <= '0;
      end
      else
      begin
         sync1 <= raw_in;
         sync2 <= sync1;
         tick_cnt <= tick ? '0 : tick_cnt + TCW'(1);
         q_valid <= ph_valid[0];
         if (ph_valid[0])
            for (int q = 0; q < NQ; q++)
               qm[q] <= mag_sq(q_re[q], q_im[q]);
         for (int s = 0; s < 2; s++)
            if (!det[s][ovp_pkg::QTY_ZERO])
               conf_cnt[s] <= '0;
            else if (q_valid && conf_cnt[s] != RESTRAINT_N)
               conf_cnt[s] <= conf_cnt[s] + RCW'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         phase_earth_phase_pickup <= '0;
         line_line_pair_pickup <= '0;
         general_pickup <= '0;
         overvoltage_trip <= 1'b0;
         remote_end_re <= '0;
         remote_end_im <= '0;
         remote_end_valid <= 1'b0;
      end
      else
      begin
         phase_earth_phase_pickup <= {det[1][2:0], det[0][2:0]};
         line_line_pair_pickup <= {det[1][5:3], det[0][5:3]};
         general_pickup <= stage_pick;
         overvoltage_trip <= |(stage_expired & trip_allow);
         remote_end_valid <= compounding;
         if (compounding && ph_valid[0])
         begin
            remote_end_re <= end_re;
            remote_end_im <= end_im;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   chk_pe_general_any: assert property (general_pickup[0] == |phase_earth_phase_pickup[0])
      else $error("phase-earth general pickup disagrees with phases");
   chk_pe_block_holds: assert property (sync2[0] [*3] |-> general_pickup[1:0] == 2'b00)
      else $error("phase-earth stage picked while blocked");
   chk_ll_block_holds: assert property (sync2[1] [*3] |-> line_line_pair_pickup == '0)
      else $error("phase-phase stage picked while blocked");
   chk_pos_block_holds: assert property (sync2[2] [*3] |-> general_pickup[5:4] == 2'b00)
      else $error("positive sequence stage picked while blocked");
   chk_neg_failure_block: assert property (internal_block [*3] |-> general_pickup[7:6] == 2'b00)
      else $error("negative sequence stage picked during voltage failure");
   chk_neg_dead_time: assert property (own_sp_dead_time [*3] |-> general_pickup[7:6] == 2'b00)
      else $error("negative sequence stage picked in dead time");
   chk_zero_dead_time: assert property ((own_sp_dead_time && !u4_single) [*3]
      |-> general_pickup[9:8] == 2'b00)
      else $error("zero sequence stage picked in dead time");
   chk_timer_cleared: assert property (!stage_pick[0] |=> stage_timer[0] == '0 && !stage_expired[0])
      else $error("stage timer kept running after dropout");
   chk_trip_cause: assert property (overvoltage_trip |-> $past(|(stage_expired & trip_allow)))
      else $error("trip without an expired tripping stage");
   chk_alarm_no_trip: assert property (trip_allow == '0 [*2] |-> !overvoltage_trip)
      else $error("trip issued in alarm-only or off mode");
   chk_restraint_wait: assert property (zero_seq_restraint_on && conf_cnt[0] != RESTRAINT_N
      |-> !stage_pick[8])
      else $error("zero sequence pickup before restraint completed");
   chk_compound_report: assert property (!compounding [*2] |-> !remote_end_valid)
      else $error("remote voltage reported without compounding");
endmodule
`default_nettype wire

//--- testbench/meas_front_end.sv
/* Measurement front-end model: seven in-phase channels, four samples a period.
   Assumes amplitudes held steady by the bench; between strobes the lines toggle. */
`timescale 1ns/100ps
`default_nettype none
module meas_front_end (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic slow,
   input wire logic [4:0][15:0] amp,
   output logic sample_valid,
   output logic [6:0][15:0] sample
);
   logic [1:0] phase;
   logic [1:0] gap;
   wire logic take = !slow || gap == 2'h2;

   function automatic logic [15:0] wave(input logic [15:0] a, input logic [1:0] p);
      return p[0] ? 16'h0000 : (p[1] ? 16'h0000 - a : a);
   endfunction

   // Stale sample lines are inverted so a design that reads off-strobe sees garbage.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         phase <= 2'h0;
         gap <= 2'h0;
         sample_valid <= 1'b0;
         sample <= '0;
      end
      else
      begin
         gap <= take ? 2'h0 : gap + 2'h1;
         sample_valid <= take;
         phase <= take ? phase + 2'h1 : phase;
         for (int k = 0; k < 7; k++)
            sample[k] <= take ? wave(amp[k < 4 ? k : 4], phase) : ~sample[k];
      end
   end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
/* Self-checking bench: table of amplitudes, then blocking, mode and timer cases.
   Assumes the front-end model and a shortened millisecond tick. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   typedef struct packed {logic [3:0][15:0] a; ovp_pkg::u4_use_e u; logic [9:0] gp;
      logic [5:0] pe; logic [5:0] ll;} row_s;
   row_s rows [6] = '{
      '{64'h00000000000003E8, ovp_pkg::U4_UNUSED, 10'h105, 6'h01, 6'h05},
      '{64'h00000000000007D0, ovp_pkg::U4_UNUSED, 10'h35F, 6'h09, 6'h2D},
      '{64'h000003E803E803E8, ovp_pkg::U4_UNUSED, 10'h301, 6'h07, 6'h00},
      '{64'h03E8000000000000, ovp_pkg::U4_DELTA, 10'h300, 6'h00, 6'h00},
      '{64'h03E8000000000000, ovp_pkg::U4_SINGLE, 10'h100, 6'h00, 6'h00},
      '{64'h07D0000000000000, ovp_pkg::U4_UNUSED, 10'h000, 6'h00, 6'h00}};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic slow = 1'b0;
   logic [4:0][15:0] amp = '0;
   logic [6:0][15:0] smp;
   logic sv, trip, rev, vt = 1'b0, asym = 1'b0, dead = 1'b0;
   logic [4:0] blk = 5'h00;
   logic rsn = 1'b0;
   logic [19:0] rre, rim;
   logic [15:0] thr1 = 16'h03E8, thr2 = 16'h0BB8, dr = 16'h01BB;
   logic [7:0] ratio = 8'hF0;
   logic [5:0] pe, ll;
   logic [9:0] gp, expd;
   ovp_pkg::fn_mode_e mode = ovp_pkg::FN_ON;
   ovp_pkg::scope_e scope = ovp_pkg::SCOPE_ENABLED;
   ovp_pkg::u4_use_e u4 = ovp_pkg::U4_UNUSED;
   int miscompares = 0, tests_run = 0, cycles = 0;

   always #20 clk = ~clk;

   meas_front_end meas_front_end_inst (.clk(clk), .rst_b(rst_b), .slow(slow), .amp(amp),
      .sample_valid(sv), .sample(smp));
   overvoltage_protection_stages #(.TICK_CYCLES(10)) overvoltage_protection_stages_inst (
      .clk(clk), .rst_b(rst_b), .sample_valid(sv), .v_l1(smp[0]), .v_l2(smp[1]),
      .v_l3(smp[2]), .fourth_voltage_input(smp[3]), .i_l1(smp[4]), .i_l2(smp[5]),
      .i_l3(smp[6]), .voltage_scope(scope), .u4_use(u4), .phase_to_delta_ratio(dr),
      .line_half_susceptance(16'h0000), .line_resistance(16'h0000),
      .line_reactance(16'h0000), .phase_earth_mode(mode), .line_line_mode(mode),
      .pos_seq_mode(mode), .neg_seq_mode(mode), .zero_seq_mode(mode),
      .phase_earth_stage1_threshold(thr1), .phase_earth_stage2_threshold(thr2),
      .line_line_stage1_threshold(thr1), .line_line_stage2_threshold(thr2),
      .pos_seq_stage1_threshold(thr1), .pos_seq_stage2_threshold(thr2),
      .neg_seq_stage1_threshold(thr1), .neg_seq_stage2_threshold(thr2),
      .zero_seq_stage1_threshold(thr1), .zero_seq_stage2_threshold(thr2),
      .phase_earth_dropout_ratio(ratio), .line_line_dropout_ratio(ratio),
      .pos_seq_dropout_ratio(ratio), .neg_seq_dropout_ratio(ratio),
      .zero_seq_dropout_ratio(ratio), .stage_delay_ms({10{16'h0003}}),
      .zero_seq_restraint_on(rsn), .phase_earth_block_in(blk[0]),
      .line_line_block_in(blk[1]), .pos_seq_block_in(blk[2]), .neg_seq_block_in(blk[3]),
      .zero_seq_block_in(blk[4]), .vt_breaker_tripped_in(vt), .asym_vfail(asym),
      .own_sp_dead_time(dead), .phase_earth_phase_pickup(pe), .line_line_pair_pickup(ll),
      .general_pickup(gp), .stage_expired(expd), .overvoltage_trip(trip),
      .remote_end_re(rre), .remote_end_im(rim), .remote_end_valid(rev));

   task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic final_report;
      $display("miscompares %0d tests_run %0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         final_report;
      end
   end

   initial
   begin
      step(20);
      cmp(gp | expd, 10'h000);
      rst_b = 1'b1;
      foreach (rows[r])
      begin
         amp = {16'h0000, rows[r].a};
         u4 = rows[r].u;
         step(20);
         cmp(gp, rows[r].gp);
         cmp({4'h0, pe}, {4'h0, rows[r].pe});
         cmp({4'h0, ll}, {4'h0, rows[r].ll});
         step(60);
         cmp(expd, rows[r].gp);
         cmp({9'h000, trip}, {9'h000, |rows[r].gp});
      end
      amp = 80'h07D0;
      mode = ovp_pkg::FN_ALARM;
      step(80);
      cmp(expd, 10'h35F);
      cmp({9'h000, trip}, 10'h000);
      mode = ovp_pkg::FN_ON;
      step(4);
      cmp({9'h000, trip}, 10'h001);
      // Blocks on neg and zero also stand in for a far-side single-pole trip.
      for (int b = 0; b < 5; b++)
      begin
         blk = 5'h01 << b;
         step(10);
         cmp(gp, 10'h35F & ~(10'h003 << 2 * b));
         cmp(expd & (10'h003 << 2 * b), 10'h000);
      end
      blk = 5'h00;
      for (int c = 0; c < 3; c++)
      begin
         {dead, vt, asym} = 3'h1 << c;
         step(10);
         cmp(gp, 10'h01F);
      end
      u4 = ovp_pkg::U4_SINGLE;
      amp[3] = 16'h07D0;
      slow = 1'b1;
      step(40);
      cmp(gp, 10'h31F);
      slow = 1'b0;
      dead = 1'b0;
      u4 = ovp_pkg::U4_UNUSED;
      amp = '0;
      scope = ovp_pkg::SCOPE_COMPOUND;
      step(20);
      cmp({9'h000, rev}, 10'h001);
      cmp({9'h000, |{rre, rim}}, 10'h000);
      scope = ovp_pkg::SCOPE_ENABLED;
      repeat (2)
      begin
         amp[0] = 16'h03E8;
         step(12);
         cmp({9'h000, gp[0]}, 10'h001);
         amp[0] = 16'h0000;
         step(10);
      end
      cmp(expd | {9'h000, rev}, 10'h000);
      // The zero sequence sum picks its first stage; restraint must hold it back for a while.
      rsn = 1'b1;
      amp[0] = 16'h03E8;
      step(8);
      cmp({9'h000, gp[8]}, 10'h000);
      step(16);
      cmp({9'h000, gp[8]}, 10'h001);
      mode = ovp_pkg::FN_OFF;
      step(6);
      cmp(gp, 10'h000);
      final_report;
   end
endmodule
`default_nettype wire
